// ===== design/ext_osc_clk_switch.sv
// Glitch-free source switch between precision and external clock enables
module ext_osc_clk_switch (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Sources as one-cycle pulses on core_clk
    input wire logic tick_int,
    input wire logic tick_ext,
    input wire logic use_ext,
    // Switched clock pulse and current source
    output logic tick_out,
    output logic ext_active
);
    logic pend_q;
    logic seen_old_q;

    // Change source only after one period of each side [RULE_16]
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_active <= 1'b0;
            pend_q <= 1'b0;
            seen_old_q <= 1'b0;
        end else if (use_ext != ext_active) begin
            if (!pend_q) begin
                pend_q <= 1'b1;
                seen_old_q <= 1'b0;
            end else if (!seen_old_q) begin
                if (ext_active ? tick_ext : tick_int)
                    seen_old_q <= 1'b1;
            end else if (ext_active ? tick_int : tick_ext) begin
                ext_active <= use_ext;
                pend_q <= 1'b0;
            end
        end else begin
            pend_q <= 1'b0;
        end
    end

    // Switched pulse, gated off while a change is pending
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            tick_out <= 1'b0;
        else if (pend_q)
            tick_out <= 1'b0;
        else
            tick_out <= ext_active ? tick_ext : tick_int;
    end
endmodule

// ===== design/ext_osc_ctrl.sv
// External oscillator control with Wishbone register access
// How it works
// RULE_01: Divide-by-2 mode halves the oscillator, giving an exact 50% duty.
// RULE_02: Software picks crystal or crystal-div2 mode before enabling.
// RULE_03: Crystal drive code 000 lowest range, 111 highest up to 25 MHz.
// RULE_04: Crystal start: enable, wait 1 ms, poll valid, then switch.
// RULE_05: A readable valid flag shows when oscillation has settled.
// RULE_06: Software avoids selecting external clock before valid.
// RULE_07: RC start: enable, poll valid, switch; no fixed wait.
// RULE_08: Capacitor mode starts like RC mode.
// RULE_09: CMOS clock mode always reads valid as zero.
// RULE_10: CMOS clock enters on second pin as digital input; first unused.
// RULE_11: RC and capacitor modes use only the second pin; the code leaves the first pin analog if a crystal mode set it.
// RULE_12: RC/C drive code 000 lowest, 111 highest up to 3.2 MHz.
// RULE_13: Software sets both pins analog before crystal mode; the code sets them itself once crystal mode is enabled.
// RULE_14: Output feeds system clock or peripheral clocks.
// RULE_15: Clock select code 001 picks the external oscillator.
// RULE_16: Source switch completes after a period of the slower clock.
// RULE_17: A mode field selects crystal, div2, RC, capacitor or CMOS.
//
// Register access over Wishbone and the register offsets were left to the implementer.
module ext_osc_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Oscillator pins
    input wire logic osc_pin_first_i,
    input wire logic osc_pin_second_i,
    input wire logic int_osc_tick,
    output logic osc_pin_first_analog,
    output logic osc_pin_second_analog,
    output logic [2:0] ext_osc_drive_code,
    output logic ext_osc_enable,
    // Clock outputs as pulses
    output logic ext_osc_tick,
    output logic periph_clk_tick,
    output logic sys_clk_tick,
    // Interrupt
    output logic irq
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] ext_osc_config_q;
    logic [2:0] sys_clock_source_select_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic ext_osc_valid_flag;
    logic ext_active;
    logic valid_prev_q;
    logic active_prev_q;
    logic [2:0] mode;
    logic osc_en;
    logic [1:0] sync_second_q;
    logic [1:0] sync_first_q;
    logic second_prev_q;
    logic osc_rise;
    logic div2_q;
    logic ext_tick_d;
    logic sys_tick;
    logic wb_hit;
    logic rd_status_clr;
    logic [1:0] irq_events;
    logic xtal_mode;
    logic rc_mode;
    logic cmos_mode;
    logic cfg_we;
    logic sel_we;
    logic mask_we;
    logic [31:0] rd_data;

    // ****************************************
    // Mode decode
    // ****************************************
    assign mode = ext_osc_config_q[ext_osc_pkg::CFG_MODE_LSB +: 3];
    assign osc_en = ext_osc_config_q[ext_osc_pkg::CFG_EN_BIT] &&
                    (mode != ext_osc_pkg::MODE_OFF);
    assign xtal_mode = (mode == ext_osc_pkg::MODE_XTAL) ||
                       (mode == ext_osc_pkg::MODE_XTAL_DIV2); // [RULE_17]
    assign rc_mode = (mode == ext_osc_pkg::MODE_RC) ||
                     (mode == ext_osc_pkg::MODE_CAP); // [RULE_17]
    assign cmos_mode = (mode == ext_osc_pkg::MODE_CMOS); // [RULE_17]

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_second_q <= 2'b00;
            sync_first_q <= 2'b00;
            second_prev_q <= 1'b0;
        end else begin
            sync_second_q <= {sync_second_q[0], osc_pin_second_i};
            sync_first_q <= {sync_first_q[0], osc_pin_first_i};
            second_prev_q <= sync_second_q[1];
        end
    end

    // All modes take the oscillation from the second pin [RULE_10] [RULE_11]
    assign osc_rise = osc_en && sync_second_q[1] && !second_prev_q;

    // ****************************************
    // Divide-by-2 stage
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            div2_q <= 1'b0;
        else if (!osc_en || mode != ext_osc_pkg::MODE_XTAL_DIV2)
            div2_q <= 1'b0;
        else if (osc_rise)
            div2_q <= ~div2_q; // [RULE_01]
    end

    // In divide-by-2 mode every second rising edge is one full output period, else every rising edge [RULE_01]
    always_comb begin
        if (mode == ext_osc_pkg::MODE_XTAL_DIV2)
            ext_tick_d = osc_rise && div2_q;
        else
            ext_tick_d = osc_rise;
    end

    // ****************************************
    // Valid detector and clock switch
    // ****************************************
    ext_osc_valid_detect u_valid (
        .core_clk(core_clk),
        .nrst(nrst),
        .enable(osc_en),
        .cmos_mode(mode == ext_osc_pkg::MODE_CMOS),
        .osc_edge(osc_rise),
        .valid(ext_osc_valid_flag)
    );

    ext_osc_clk_switch u_switch (
        .core_clk(core_clk),
        .nrst(nrst),
        .tick_int(int_osc_tick),
        .tick_ext(ext_tick_d),
        .use_ext(sys_clock_source_select_q == ext_osc_pkg::SRC_EXTERNAL),
        .tick_out(sys_tick),
        .ext_active(ext_active)
    ); // [RULE_15] [RULE_16]

    // ****************************************
    // Pin and clock outputs
    // ****************************************
    // First pin analog for a crystal, left alone in RC and C modes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            osc_pin_first_analog <= 1'b0;
        else if (osc_en && xtal_mode)
            osc_pin_first_analog <= 1'b1;
        else if (!(osc_en && rc_mode))
            osc_pin_first_analog <= 1'b0; // [RULE_11]
    end

    // CMOS mode leaves the second pin digital [RULE_10]
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            osc_pin_second_analog <= 1'b0;
        else
            osc_pin_second_analog <= osc_en && !cmos_mode; // [RULE_11]
    end

    // Drive code and enable follow the configuration
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_osc_drive_code <= 3'h0;
            ext_osc_enable <= 1'b0;
        end else begin
            ext_osc_drive_code <= ext_osc_config_q[
                ext_osc_pkg::CFG_DRIVE_LSB +: 3]; // [RULE_03] [RULE_12]
            ext_osc_enable <= osc_en;
        end
    end

    // Clock pulses for peripherals and the system
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_osc_tick <= 1'b0;
            periph_clk_tick <= 1'b0;
            sys_clk_tick <= 1'b0;
        end else begin
            ext_osc_tick <= ext_tick_d;
            periph_clk_tick <= ext_tick_d; // [RULE_14]
            sys_clk_tick <= sys_tick; // [RULE_14]
        end
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_status_clr = wb_hit && !wb_we_i &&
                           (wb_adr_i == {1'b0, ext_osc_pkg::ADDR_IRQ_ST});

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_hit;
    end

    // Register write strobes; only byte lane 0 is used
    assign cfg_we = wb_hit && wb_we_i && wb_sel_i[0] &&
                    (wb_adr_i == {1'b0, ext_osc_pkg::ADDR_CONFIG});
    assign sel_we = wb_hit && wb_we_i && wb_sel_i[0] &&
                    (wb_adr_i == {1'b0, ext_osc_pkg::ADDR_CLK_SELECT});
    assign mask_we = wb_hit && wb_we_i && wb_sel_i[0] &&
                     (wb_adr_i == ext_osc_pkg::ADDR_IRQ_MASK);

    // Configuration; mode field is bits 6:4 [RULE_17]
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            ext_osc_config_q <= ext_osc_pkg::CONFIG_RST;
        else if (cfg_we)
            ext_osc_config_q <= wb_dat_i[7:0];
    end

    // Clock source select [RULE_15]
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            sys_clock_source_select_q <= ext_osc_pkg::CLK_SELECT_RST;
        else if (sel_we)
            sys_clock_source_select_q <= wb_dat_i[2:0];
    end

    // Interrupt mask
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            irq_mask_q <= ext_osc_pkg::MASK_RST;
        else if (mask_we)
            irq_mask_q <= wb_dat_i[1:0];
    end

    // Read data mux
    always_comb begin
        case (wb_adr_i)
            {1'b0, ext_osc_pkg::ADDR_CONFIG}:
                rd_data = {24'h00_0000, ext_osc_config_q};
            {1'b0, ext_osc_pkg::ADDR_CLK_SELECT}:
                rd_data = {29'h0000_0000, sys_clock_source_select_q};
            {1'b0, ext_osc_pkg::ADDR_STATUS}:
                rd_data = {30'h0000_0000, ext_active,
                           ext_osc_valid_flag}; // [RULE_05]
            {1'b0, ext_osc_pkg::ADDR_IRQ_ST}:
                rd_data = {30'h0000_0000, irq_status_q};
            ext_osc_pkg::ADDR_IRQ_MASK:
                rd_data = {30'h0000_0000, irq_mask_q};
            default:
                rd_data = 32'h0000_0000;
        endcase
    end

    // Read data register, held until the next read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_hit && !wb_we_i)
            wb_dat_o <= rd_data;
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            valid_prev_q <= 1'b0;
            active_prev_q <= 1'b0;
        end else begin
            valid_prev_q <= ext_osc_valid_flag;
            active_prev_q <= ext_active;
        end
    end

    assign irq_events = {ext_active != active_prev_q,
                         ext_osc_valid_flag && !valid_prev_q};

    // Read clears; a new event in the same cycle wins
    for (genvar i = 0; i < 2; i++) begin : g_irq_bit
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst)
                irq_status_q[i] <= 1'b0;
            else if (irq_events[i])
                irq_status_q[i] <= 1'b1;
            else if (rd_status_clr)
                irq_status_q[i] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(irq_status_q & irq_mask_q);
    end
endmodule

// ===== design/ext_osc_pkg.sv
// Package: register map, fields, modes and timing for the external oscillator
package ext_osc_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_CLK_SELECT = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_ST = 4'hC;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_DRIVE_LSB = 0;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_EN_BIT = 7;
    localparam int ST_VALID_BIT = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int IRQ_VALID_BIT = 0;
    localparam int IRQ_SWITCH_BIT = 1;

    // ****************************************
    // Modes and encodings
    // ****************************************
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_XTAL = 3'h1;
    localparam logic [2:0] MODE_XTAL_DIV2 = 3'h2;
    localparam logic [2:0] MODE_RC = 3'h3;
    localparam logic [2:0] MODE_CAP = 3'h4;
    localparam logic [2:0] MODE_CMOS = 3'h5;

    localparam logic [2:0] SRC_PRECISION = 3'h0;
    localparam logic [2:0] SRC_EXTERNAL = 3'h1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [2:0] CLK_SELECT_RST = 3'h2;
    localparam logic [1:0] MASK_RST = 2'h0;

    // ****************************************
    // Valid detector: edges seen on the second pin before stable, idle cycles before restart
    // ****************************************
    localparam logic [7:0] VALID_EDGES = 8'h40;
    localparam logic [15:0] STALL_CYCLES = 16'h0100;

endpackage

// ===== design/ext_osc_valid_detect.sv
// Valid detector: counts oscillation edges and flags a stable oscillator
module ext_osc_valid_detect (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Control
    input wire logic enable,
    input wire logic cmos_mode,
    input wire logic osc_edge,
    // Status
    output logic valid
);
    logic [7:0] edge_cnt_q;
    logic [15:0] idle_cnt_q;

    // Edge count, restarted on disable or on a stalled oscillator
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            edge_cnt_q <= 8'h00;
            idle_cnt_q <= 16'h0000;
        end else if (!enable) begin
            edge_cnt_q <= 8'h00;
            idle_cnt_q <= 16'h0000;
        end else if (osc_edge) begin
            idle_cnt_q <= 16'h0000;
            if (edge_cnt_q != ext_osc_pkg::VALID_EDGES)
                edge_cnt_q <= edge_cnt_q + 8'h01;
        end else if (idle_cnt_q == ext_osc_pkg::STALL_CYCLES) begin
            edge_cnt_q <= 8'h00;
        end else begin
            idle_cnt_q <= idle_cnt_q + 16'h0001;
        end
    end

    // CMOS input never reports valid [RULE_09]
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            valid <= 1'b0;
        else
            valid <= enable && !cmos_mode &&
                     (edge_cnt_q == ext_osc_pkg::VALID_EDGES); // [RULE_05]
    end
endmodule

// ===== tb/ext_osc_ctrl_assertions.sv
// Checker on the external oscillator control ports
module ext_osc_ctrl_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Oscillator side
    input wire logic osc_pin_first_analog,
    input wire logic osc_pin_second_analog,
    input wire logic [2:0] ext_osc_drive_code,
    input wire logic ext_osc_enable,
    input wire logic ext_osc_tick,
    input wire logic periph_clk_tick
);
    logic take;
    logic cfg_wr;
    logic [2:0] md;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cfg_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 5'h00;
    assign md = wb_dat_i[6:4];
    // ****************************************
    // Properties
    // ****************************************
    ack_answer_a:
        assert property (take |=> wb_ack_o) else $error("no ack");
    ack_pulse_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    upper_zero_a:
        assert property (take && !wb_we_i |=> wb_dat_o[31:8] == 24'h00_0000)
            else $error("upper read bits set");
    drive_code_a:
        assert property (cfg_wr |-> ##2
            ext_osc_drive_code == $past(wb_dat_i[2:0], 2)) else $error("code");
    osc_enable_a:
        assert property (cfg_wr |-> ##2 ext_osc_enable ==
            ($past(wb_dat_i[7], 2) && $past(md, 2) != 3'h0)) else $error("en");
    cmos_pin_a:
        assert property (cfg_wr && md == ext_osc_pkg::MODE_CMOS |-> ##2
            !osc_pin_second_analog) else $error("second pin analog in cmos");
    rc_pins_a:
        assert property (cfg_wr && wb_dat_i[7] && (md == ext_osc_pkg::MODE_RC
            || md == ext_osc_pkg::MODE_CAP) |-> ##2 osc_pin_second_analog &&
            $stable(osc_pin_first_analog)) else $error("rc pin use");
    periph_tick_a:
        assert property (periph_clk_tick == ext_osc_tick)
            else $error("peripheral tick differs");
endmodule

bind ext_osc_ctrl ext_osc_ctrl_assertions ext_osc_ctrl_assertions_inst (
    .core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .osc_pin_first_analog,
    .osc_pin_second_analog, .ext_osc_drive_code, .ext_osc_enable,
    .ext_osc_tick, .periph_clk_tick
);

// ===== tb/ext_osc_ctrl_bench.sv
// Self-checking bench for the external oscillator control block
module ext_osc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string what; logic [31:0] val; logic [31:0] msk;} note_t;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic int_osc_tick = 1'b0;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic wb_ack_o, osc_pin_first_i, osc_pin_second_i, irq, sys_clk_tick;
    logic osc_pin_first_analog, osc_pin_second_analog, ext_osc_enable;
    logic ext_osc_tick, periph_clk_tick;
    logic [2:0] ext_osc_drive_code;
    logic [31:0] wb_dat_o, rd;
    logic [7:0] v;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 38450;
    int k;
    note_t note_q[$];

    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) int_osc_tick <= ($random(seed) & 3) == 0;

    ext_osc_source ext_osc_source_inst (
        .run, .slow, .pin_first(osc_pin_first_i), .pin_second(osc_pin_second_i)
    );
    ext_osc_ctrl ext_osc_ctrl_inst (
        .core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .osc_pin_first_i,
        .osc_pin_second_i, .int_osc_tick, .osc_pin_first_analog,
        .osc_pin_second_analog, .ext_osc_drive_code, .ext_osc_enable,
        .ext_osc_tick, .periph_clk_tick, .sys_clk_tick, .irq
    );

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // Bus cycles, polling and tick timing
    // ****************************************
    task automatic wb(logic we, logic [4:0] adr, logic [31:0] dat,
                      logic [3:0] sel = 4'hF);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, sel};
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            check("ack", 32'h0000_0001, 32'h0000_0000);
            report_and_stop();
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic rdc(string what, logic [4:0] adr, logic [31:0] exp,
                       logic [31:0] msk);
        note_q.push_back('{what, exp, msk});
        wb(1'b0, adr, 32'h0000_0000);
    endtask

    task automatic poll(int b, logic val);
        int n;
        n = 0;
        do begin
            rdc("poll", 5'h08, 32'h0000_0000, 32'h0000_0000);
            n++;
        end while (rd[b] !== val && n < 1000);
        check("status poll", 32'(val), 32'(rd[b]));
    endtask

    task automatic gap(logic [31:0] exp);
        int n;
        n = 0;
        do @(posedge core_clk); while (ext_osc_tick !== 1'b1 && ++n < 100);
        n = 0;
        do @(posedge core_clk); while (ext_osc_tick !== 1'b1 && ++n < 100);
        check("tick gap", exp, 32'(n + 1));
    endtask

    // Result watcher: read data against the oldest note
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && note_q.size() > 0) begin
            if (note_q[0].msk != 32'h0000_0000) begin
                check(note_q[0].what, note_q[0].val, wb_dat_o & note_q[0].msk);
            end
            void'(note_q.pop_front());
        end
    end

    initial begin
        #(60_000 * 25);
        check("watchdog", 32'h0000_0000, 32'h0000_0001);
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        rdc("config", 5'h00, 32'(ext_osc_pkg::CONFIG_RST), ALL);
        rdc("clock select", 5'h04, 32'(ext_osc_pkg::CLK_SELECT_RST), ALL);
        rdc("status", 5'h08, 32'h0000_0000, ALL);
        rdc("irq status", 5'h0C, 32'h0000_0000, ALL);
        rdc("mask", 5'h10, 32'(ext_osc_pkg::MASK_RST), ALL);
        rdc("unmapped", 5'h14, 32'h0000_0000, ALL);
        $display("test reset values done");
        for (int m = 1; m <= 5; m++) begin
            for (int c = 0; c < 8; c++) begin
                v = {1'b0, m[2:0], 1'b0, c[2:0]};
                wb(1'b1, 5'h00, ({$random(seed)} & 32'hFFFF_FF00) | 32'(v));
                rdc("config", 5'h00, 32'(v), ALL);
            end
        end
        wb(1'b1, 5'h00, 32'h0000_00FF, 4'hE);
        rdc("config", 5'h00, 32'h0000_0057, ALL);
        $display("test modes and codes done");
        wb(1'b1, 5'h10, 32'h0000_0001);
        run <= 1'b1;
        wb(1'b1, 5'h00, 32'h0000_0097);
        check("irq", 32'h0000_0000, 32'(irq));
        repeat (40_000) @(posedge core_clk);
        check("pin1", 32'h0000_0001, 32'(osc_pin_first_analog));
        check("pin2", 32'h0000_0001, 32'(osc_pin_second_analog));
        poll(0, 1'b1);
        check("irq", 32'h0000_0001, 32'(irq));
        rdc("irq status", 5'h0C, 32'h0000_0001, 32'h0000_0001);
        rdc("irq status", 5'h0C, 32'h0000_0000, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check("irq", 32'h0000_0000, 32'(irq));
        gap(32'h0000_0006);
        wb(1'b1, 5'h04, 32'h0000_0001);
        poll(1, 1'b1);
        rdc("irq status", 5'h0C, 32'h0000_0002, 32'h0000_0002);
        check("irq", 32'h0000_0000, 32'(irq));
        k = 0;
        repeat (120) @(posedge core_clk) k += int'(sys_clk_tick);
        check("sys ticks", 32'h0000_0014, 32'(k));
        wb(1'b1, 5'h00, 32'h0000_00A7);
        repeat (30) @(posedge core_clk);
        gap(32'h0000_000C);
        wb(1'b1, 5'h04, 32'h0000_0000);
        poll(1, 1'b0);
        wb(1'b1, 5'h00, 32'h0000_00B7);
        repeat (2) @(posedge core_clk);
        check("pin", 32'h0000_0001, 32'(osc_pin_first_analog));
        $display("test crystal and switch done");
        wb(1'b1, 5'h00, 32'h0000_00D0);
        repeat (600) @(posedge core_clk);
        rdc("status", 5'h08, 32'h0000_0000, 32'h0000_0001);
        slow <= 1'b1;
        wb(1'b1, 5'h00, 32'h0000_00B2);
        poll(0, 1'b1);
        wb(1'b1, 5'h00, 32'h0000_0000);
        poll(0, 1'b0);
        wb(1'b1, 5'h00, 32'h0000_00C5);
        poll(0, 1'b1);
        run <= 1'b0;
        repeat (ext_osc_pkg::STALL_CYCLES + 20) @(posedge core_clk);
        rdc("status", 5'h08, 32'h0000_0000, 32'h0000_0001);
        $display("test cmos, rc and capacitor done");
        report_and_stop();
    end
endmodule

// ===== tb/ext_osc_source.sv
// Partner model: crystal, RC, capacitor or CMOS clock on the two pins
module ext_osc_source (
    // Control from the bench
    input wire logic run,
    input wire logic slow,
    // Oscillator pins
    output logic pin_first,
    output logic pin_second
);
    timeunit 1ns;
    timeprecision 1ps;
    // Oscillation on the second pin, pulled high while stopped
    initial begin
        pin_second = 1'b1;
        #7;
        forever begin
            #(slow ? 200 : 75);
            pin_second = run ? ~pin_second : 1'b1;
        end
    end
    // First pin swings in antiphase and must not matter
    assign pin_first = ~pin_second;
endmodule
